// file: logic/emb_pkg.sv
// Purpose: shared constants and types for the external memory bus block
// Assumes: one 100 MHz clock, synchronous active-high reset
// Notes: bus configuration encoding is a local choice, codes listed below
package emb_pkg;
  // ==========================================================================
  // Widths
  localparam int unsigned EMB_ADDR_W = 18; // Full external address width
  localparam int unsigned EMB_DATA_W = 8; // Multiplexed byte width
  localparam int unsigned EMB_CODE_W = 15; // On-chip code range, address bits
  // ==========================================================================
  // Address field positions
  localparam int unsigned EMB_EIGHTEEN_POS = 17; // Eighteenth address bit
  localparam int unsigned EMB_SEVENTEEN_POS = 16; // Seventeenth address bit
  localparam int unsigned EMB_UP_HI = 15; // Upper address lines, top
  localparam int unsigned EMB_UP_LO = 8; // Upper address lines, bottom
  // ==========================================================================
  // Bus configuration codes {high,low}
  localparam logic [1:0] EMB_CFG_EXT18 = 2'h0; // 18-bit bus, strobe-only reads
  localparam logic [1:0] EMB_CFG_EXT17 = 2'h1; // 17-bit bus
  localparam logic [1:0] EMB_CFG_DRD = 2'h2; // 16-bit, separate data read strobe
  localparam logic [1:0] EMB_CFG_STD = 2'h3; // 16-bit, code strobe covers all
  // ==========================================================================
  // Timing counts
  localparam int unsigned EMB_ALE_NS = 10; // Address latch strobe least width
  localparam int unsigned EMB_CLK_NS = 10; // Clock period
  localparam int unsigned EMB_ALE_CYC = (EMB_ALE_NS + EMB_CLK_NS - 1) / EMB_CLK_NS;
  localparam int unsigned EMB_ADDR_CYC = 1; // Address hold after strobe
  localparam logic [7:0] EMB_PORT_FLOAT = 8'hFF; // Port written with ones
  // ==========================================================================
  // Bus cycle states, one-hot
  typedef enum logic [4:0] {
    EMB_IDLE = 5'h01,
    EMB_ALE = 5'h02,
    EMB_ADDR = 5'h04,
    EMB_DATA = 5'h08,
    EMB_DONE = 5'h10
  } emb_state_t;
  // Upper bits decide pin roles
  function automatic logic emb_eighteen_on(input logic [1:0] cfg);
    return cfg == EMB_CFG_EXT18;
  endfunction
  function automatic logic emb_seventeen_on(input logic [1:0] cfg);
    return (cfg == EMB_CFG_EXT18) || (cfg == EMB_CFG_EXT17);
  endfunction
endpackage

// file: logic/emb_cfg_if.sv
// Purpose: carries strap and configuration between the bus modules
// Assumes: single clock domain
// Notes: produced by emb_strap, read by emb_bus
`timescale 1ns/100ps
`default_nettype none
interface emb_cfg_if;
  logic ext_only; // Sampled strap: all code external
  logic eighteen_en; // Eighteenth bit pin is address
  logic seventeen_en; // Seventeenth bit pin is address
  modport src(output ext_only, output eighteen_en, output seventeen_en);
  modport dst(input ext_only, input eighteen_en, input seventeen_en);
endinterface
`default_nettype wire

// file: logic/emb_strap.sv
// Purpose: catches the code select strap at reset, decodes bus configuration
// Assumes: strap stable while srst is high
// Notes: value held until next reset
`timescale 1ns/100ps
`default_nettype none
module emb_strap
  import emb_pkg::*;
(
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic ext_code_select_n,
  input wire logic bus_cfg_bit_low,
  input wire logic bus_cfg_bit_high,
  emb_cfg_if.src cfg
);
  // ==========================================================================
  // Strap capture
  logic ext_only_r; // Latched strap, high means all code external
  // Sample only during reset, ignore pin afterwards
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      ext_only_r <= ~ext_code_select_n; // [R10] [R08]
    end
  end
  assign cfg.ext_only = ext_only_r;
  // Pin roles from static configuration
  assign cfg.eighteen_en = emb_eighteen_on({bus_cfg_bit_high, bus_cfg_bit_low}); // [R01] [R15]
  assign cfg.seventeen_en = emb_seventeen_on({bus_cfg_bit_high, bus_cfg_bit_low}); // [R02] [R14]
  // Strap holds while out of reset
  strap_hold_a: assert property (@(posedge clk_sys) !srst && !$past(srst) |-> $stable(ext_only_r)) // [R10]
    else $error("strap value changed outside reset");
endmodule
`default_nettype wire

// file: logic/emb_bus.sv
// Purpose: external memory bus sequencer, address/data multiplexing
// Assumes: core requests are level held until done pulses
// Notes: open-drain port drive is modelled as out/enable pairs
//
// Behaviour
// [R01] Eighteenth address bit only in extended configs
// [R02] Seventeenth address bit only in extended configs
// [R03] Upper byte dedicated, low byte multiplexed
// [R04] Latch strobe opens every cycle, address valid
// [R05] Outside latch captures low address
// [R06] Low wait input stretches the cycle
// [R07] Unconnected wait reads inactive
// [R08] Strap low: every code fetch external
// [R09] Strap high: on-chip range internal
// [R10] Strap sampled in reset, held
// [R11] Codeless parts tie strap low
// [R12] Muxed port open drain, ones float
// [R13] Code strobe range set by configuration
// [R14] Shared pin: data read strobe or address
// [R15] Configuration bits are static inputs
`timescale 1ns/100ps
`default_nettype none
module emb_bus
  import emb_pkg::*;
#(
  parameter int unsigned CODE_W = EMB_CODE_W // On-chip code range bits
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic ext_code_select_n,
  input wire logic bus_cfg_bit_low,
  input wire logic bus_cfg_bit_high,
  input wire logic async_wait_n,
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic req_code,
  input wire logic [EMB_ADDR_W-1:0] req_addr,
  input wire logic [EMB_DATA_W-1:0] req_wdata,
  input wire logic [EMB_DATA_W-1:0] muxed_addr_data_in,
  output logic [EMB_DATA_W-1:0] muxed_addr_data_out,
  output logic [EMB_DATA_W-1:0] muxed_addr_data_oe_n,
  output logic [EMB_UP_HI-EMB_UP_LO:0] upper_addr_lines,
  output logic ext_addr_bit_eighteen,
  output logic ext_addr_bit_seventeen,
  output logic addr_latch_strobe,
  output logic code_read_strobe_n,
  output logic data_read_strobe_n,
  output logic write_strobe_n,
  output logic req_done,
  output logic req_internal,
  output logic [EMB_DATA_W-1:0] req_rdata
);
  // ==========================================================================
  // Elaboration checks
  // Range must fit below the extended address bits
  if (CODE_W < 1 || CODE_W > EMB_UP_HI + 1) begin : g_chk
    $error("CODE_W out of range");
  end
  // ==========================================================================
  // Configuration and strap
  emb_cfg_if cfg_if ();
  emb_strap u_strap (
    .clk_sys(clk_sys),
    .srst(srst),
    .ext_code_select_n(ext_code_select_n),
    .bus_cfg_bit_low(bus_cfg_bit_low),
    .bus_cfg_bit_high(bus_cfg_bit_high),
    .cfg(cfg_if.src)
  );
  logic [1:0] cfg_code; // Static bus configuration
  assign cfg_code = {bus_cfg_bit_high, bus_cfg_bit_low};
  // ==========================================================================
  // Request classification
  logic on_chip; // Code fetch served by on-chip memory
  // Strap high and address inside range keeps fetch internal
  assign on_chip = req_code && !cfg_if.ext_only
    && (req_addr[EMB_ADDR_W-1:CODE_W] == '0); // [R08] [R09]
  logic use_code_strobe; // Read uses code strobe, not data strobe
  // Only the split-strobe configuration keeps data reads off the code strobe
  assign use_code_strobe = req_code || (cfg_code != EMB_CFG_DRD); // [R13] [R14]
  // ==========================================================================
  // Sequencer state
  emb_state_t state_r, state_nxt;
  logic wait_hold; // Wait input low stretches data phase
  // Pull-up modelled outside; a high input never stretches
  // Limitation: wait is taken as synchronous; a raw pin needs two flops ahead
  assign wait_hold = !async_wait_n; // [R06] [R07]
  // Next state
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      EMB_IDLE: begin
        // External cycle opens with the latch strobe
        if (req_valid && !on_chip) begin
          state_nxt = EMB_ALE;
        end else if (req_valid) begin
          // On-chip fetch answers at once, the bus stays quiet
          state_nxt = EMB_DONE;
        end
      end
      EMB_ALE: begin
        state_nxt = EMB_ADDR;
      end
      EMB_ADDR: begin
        state_nxt = EMB_DATA;
      end
      EMB_DATA: begin
        // Held here while the wait input is low
        if (!wait_hold) begin // [R06]
          state_nxt = EMB_DONE;
        end
      end
      EMB_DONE: begin
        state_nxt = EMB_IDLE;
      end
      default: begin
        // Illegal one-hot code falls back to idle
        state_nxt = EMB_IDLE;
      end
    endcase
  end
  // State register
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      state_r <= EMB_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end
  // ==========================================================================
  // Captured request
  logic [EMB_ADDR_W-1:0] addr_r; // Address of cycle in flight
  logic write_r; // Cycle is a write
  logic code_strobe_r; // Read uses code strobe
  logic [EMB_DATA_W-1:0] wdata_r; // Write byte
  // Capture when leaving idle
  // Later changes on the request lines never reach the pins
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      addr_r <= '0;
      write_r <= 1'b0;
      code_strobe_r <= 1'b0;
      wdata_r <= '0;
    end else if (state_r == EMB_IDLE && req_valid) begin
      addr_r <= req_addr;
      write_r <= req_write;
      code_strobe_r <= use_code_strobe;
      wdata_r <= req_wdata;
    end
  end
  // ==========================================================================
  // Address pins: upper byte and extended bits land with the latch strobe
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      upper_addr_lines <= '0;
      ext_addr_bit_eighteen <= 1'b0;
      ext_addr_bit_seventeen <= 1'b0;
    end else begin
      if (state_nxt == EMB_ALE) begin
        upper_addr_lines <= req_addr[EMB_UP_HI:EMB_UP_LO]; // [R03]
        ext_addr_bit_eighteen <= req_addr[EMB_EIGHTEEN_POS]; // [R01]
        ext_addr_bit_seventeen <= req_addr[EMB_SEVENTEEN_POS]; // [R02]
      end
      // Disabled bits drop at once, so a configuration change leaves no stale level
      if (!cfg_if.eighteen_en) begin
        ext_addr_bit_eighteen <= 1'b0; // [R01]
      end
      if (!cfg_if.seventeen_en) begin
        ext_addr_bit_seventeen <= 1'b0; // [R02]
      end
    end
  end
  // ==========================================================================
  // Latch strobe, high for the first address-phase cycle only
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      addr_latch_strobe <= 1'b0;
    end else begin
      addr_latch_strobe <= (state_nxt == EMB_ALE); // [R04] [R05]
    end
  end
  // ==========================================================================
  // Multiplexed port, open drain: ones float, zeros pull low
  logic [EMB_DATA_W-1:0] port_val; // Value written to the port
  always_comb begin
    port_val = EMB_PORT_FLOAT;
    if (state_nxt == EMB_ALE) begin
      // Low address under the strobe
      port_val = req_addr[EMB_DATA_W-1:0]; // [R03]
    end else if (state_nxt == EMB_ADDR) begin
      // Held one more cycle so the outside latch closes safely
      port_val = addr_r[EMB_DATA_W-1:0];
    end else if (state_nxt == EMB_DATA && write_r) begin
      // Write byte; reads leave the port floating for the memory
      port_val = wdata_r; // [R03]
    end
  end
  // Enable register drives the pins; the data register stays zero
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      muxed_addr_data_out <= '0;
      muxed_addr_data_oe_n <= EMB_PORT_FLOAT;
    end else begin
      muxed_addr_data_out <= '0; // Only ever drives low
      muxed_addr_data_oe_n <= port_val; // [R12]
    end
  end
  // ==========================================================================
  // Read and write strobes
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      code_read_strobe_n <= 1'b1;
      data_read_strobe_n <= 1'b1;
      write_strobe_n <= 1'b1;
    end else begin
      // Code strobe covers every read the data strobe does not
      code_read_strobe_n <= !(state_nxt == EMB_DATA && !write_r && code_strobe_r); // [R13]
      // Shared pin is a strobe only when not an address bit
      data_read_strobe_n <= !(state_nxt == EMB_DATA && !write_r && !code_strobe_r
        && !cfg_if.seventeen_en); // [R14]
      // Write strobe stands for the whole data phase
      write_strobe_n <= !(state_nxt == EMB_DATA && write_r);
    end
  end
  // ==========================================================================
  // Completion and read data
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      req_done <= 1'b0;
      req_internal <= 1'b0;
      req_rdata <= '0;
    end else begin
      req_done <= (state_nxt == EMB_DONE);
      // On-chip flag kept until the next request
      if (state_r == EMB_IDLE && req_valid) begin
        req_internal <= on_chip; // [R09]
      end
      // Read byte taken on the edge that closes the data phase
      if (state_r == EMB_DATA && !wait_hold && !write_r) begin
        req_rdata <= muxed_addr_data_in;
      end
    end
  end
  // ==========================================================================
  // Checks
  // Strobe high for exactly one cycle, then low
  sequence s_addr_phase;
    addr_latch_strobe ##1 !addr_latch_strobe;
  endsequence
  // Data phase held by a low wait input
  sequence s_stretch;
    state_r == EMB_DATA && !async_wait_n;
  endsequence
  // External cycle whose wait input stays high from the strobe on
  sequence s_no_wait;
    $rose(addr_latch_strobe) ##0 async_wait_n [*3];
  endsequence
  // On-chip answer: no latch strobe, completion already showing
  sequence s_int_answer;
    !addr_latch_strobe && req_done;
  endsequence
  // Latch strobe is a single-cycle pulse
  latch_strobe_a: assert property (@(posedge clk_sys) disable iff (srst) // [R04]
    $rose(addr_latch_strobe) |-> s_addr_phase)
    else $error("latch strobe not one cycle");
  // Low address stands on the port under the strobe
  latch_addr_a: assert property (@(posedge clk_sys) disable iff (srst) // [R04]
    addr_latch_strobe |-> muxed_addr_data_oe_n == addr_r[EMB_DATA_W-1:0])
    else $error("low address missing under strobe");
  // A low wait input keeps the data phase open
  wait_stretch_a: assert property (@(posedge clk_sys) disable iff (srst) // [R06]
    s_stretch |=> state_r == EMB_DATA && !req_done)
    else $error("cycle ended during wait");
  // A high wait input adds no cycle
  wait_free_a: assert property (@(posedge clk_sys) disable iff (srst) // [R07]
    s_no_wait |-> ##[0:2] req_done)
    else $error("cycle stretched without wait");
  // Eighteenth bit stays low outside the 18-bit arrangement
  eighteen_gate_a: assert property (@(posedge clk_sys) disable iff (srst) // [R01]
    !cfg_if.eighteen_en && $stable(cfg_code) |=> !ext_addr_bit_eighteen)
    else $error("eighteenth bit driven outside extended mode");
  // Seventeenth bit stays low outside the extended arrangements
  seventeen_gate_a: assert property (@(posedge clk_sys) disable iff (srst) // [R02]
    !cfg_if.seventeen_en && $stable(cfg_code) |=> !ext_addr_bit_seventeen)
    else $error("seventeenth bit driven outside extended mode");
  // Strap low sends every code fetch to the bus
  ext_fetch_a: assert property (@(posedge clk_sys) disable iff (srst) // [R08]
    state_r == EMB_IDLE && req_valid && req_code && cfg_if.ext_only |=> addr_latch_strobe)
    else $error("strap low fetch not external");
  // On-chip fetch leaves the bus untouched
  int_fetch_a: assert property (@(posedge clk_sys) disable iff (srst) // [R09]
    state_r == EMB_IDLE && req_valid && on_chip |=> s_int_answer)
    else $error("on-chip fetch used the bus");
  // Port only ever pulls low
  drain_only_a: assert property (@(posedge clk_sys) disable iff (srst) // [R12]
    muxed_addr_data_out == '0)
    else $error("port drove a high level");
  // Never both read strobes at once
  rd_excl_a: assert property (@(posedge clk_sys) disable iff (srst) // [R14]
    !(!code_read_strobe_n && !data_read_strobe_n))
    else $error("both read strobes active");
endmodule
`default_nettype wire

// file: dv/emb_mem_model.sv
// Purpose: external code/data memory behind an address latch
// Assumes: strobes and latch strobe from the bus block, one clock
// Notes: drives data only while a read strobe is low; the port pull-up covers the rest
`timescale 1ns/100ps
`default_nettype none
module emb_mem_model
  import emb_pkg::*;
(
  input wire logic clk_sys,
  input wire logic addr_latch_strobe,
  input wire logic [7:0] mux_level,
  input wire logic [7:0] upper_addr_lines,
  input wire logic ext_addr_bit_eighteen,
  input wire logic ext_addr_bit_seventeen,
  input wire logic code_read_strobe_n,
  input wire logic data_read_strobe_n,
  input wire logic write_strobe_n,
  input wire logic [3:0] wait_cycles,
  output logic mem_drive,
  output logic [7:0] mem_data,
  output logic async_wait_n
);
  logic [17:0] lat_addr_r; // Latched address
  logic [17:0] key; // Address seen at the latch strobe
  logic [7:0] mem_r [0:262143]; // Whole external space, pattern filled
  logic [3:0] wcnt_r; // Edges since a strobe went low
  logic act; // Any read or write strobe active
  // ==========================================================================
  // Strobe decode
  assign act = !code_read_strobe_n || !data_read_strobe_n || !write_strobe_n;
  assign mem_drive = !code_read_strobe_n || !data_read_strobe_n;
  // Combinational so the first data-phase edge already sees the wait
  assign async_wait_n = !(act && (wcnt_r < wait_cycles));
  // ==========================================================================
  // Latch, storage and wait counter
  always @(posedge clk_sys) begin
    if (addr_latch_strobe) begin
      key = {ext_addr_bit_eighteen, ext_addr_bit_seventeen, upper_addr_lines, mux_level};
      lat_addr_r <= key;
      mem_data <= mem_r[key];
    end
    if (!write_strobe_n) begin
      mem_r[lat_addr_r] <= mux_level;
    end
    wcnt_r <= act ? ((wcnt_r == 4'hF) ? wcnt_r : wcnt_r + 4'h1) : 4'h0;
  end
  // Unwritten bytes read as low address xor upper lines
  initial begin
    wcnt_r <= 4'h0;
    for (int i = 0; i < 262144; i++) begin
      mem_r[i] <= 8'(i) ^ 8'(i >> 8);
    end
  end
endmodule
`default_nettype wire

// file: dv/test_external_memory_bus_interface.sv
// Purpose: self-checking bench for the external memory bus block
// Assumes: 100 MHz clock, inputs driven 1 ns after the rising edge
// Notes: the port level is worked out from open-drain enables and memory drive
`timescale 1ns/100ps
`default_nettype none
module test_external_memory_bus_interface;
  import emb_pkg::*;
  logic clk_sys = 1'b0, srst = 1'b1, strap = 1'b0, cfg_lo = 1'b0, cfg_hi = 1'b0;
  logic req_valid = 1'b0, req_write = 1'b0, req_code = 1'b0;
  logic [17:0] req_addr = 18'h0;
  logic [7:0] req_wdata = 8'h0;
  logic [3:0] wait_cycles = 4'h0; // Wait states the memory inserts
  logic [7:0] mux_out, oe_n, mux_lvl, upper, rdata, mem_data;
  logic bit18, bit17, ale, crd_n, drd_n, wr_n, done, internal, wait_n, mem_drive;
  int num_errors = 0;
  int n_compared = 0;
  // ==========================================================================
  // Clock and port wire level: pulled low by enabled bits, else memory or pull-up
  always #5 clk_sys = ~clk_sys;
  assign mux_lvl = (~oe_n & mux_out) | (oe_n & (mem_drive ? mem_data : 8'hFF));
  emb_bus i_dut (.clk_sys(clk_sys), .srst(srst), .ext_code_select_n(strap), .bus_cfg_bit_low(cfg_lo),
    .bus_cfg_bit_high(cfg_hi), .async_wait_n(wait_n), .req_valid(req_valid), .req_write(req_write),
    .req_code(req_code), .req_addr(req_addr), .req_wdata(req_wdata), .muxed_addr_data_in(mux_lvl),
    .muxed_addr_data_out(mux_out), .muxed_addr_data_oe_n(oe_n), .upper_addr_lines(upper),
    .ext_addr_bit_eighteen(bit18), .ext_addr_bit_seventeen(bit17), .addr_latch_strobe(ale),
    .code_read_strobe_n(crd_n), .data_read_strobe_n(drd_n), .write_strobe_n(wr_n), .req_done(done),
    .req_internal(internal), .req_rdata(rdata));
  emb_mem_model i_mem (.clk_sys(clk_sys), .addr_latch_strobe(ale), .mux_level(mux_lvl),
    .upper_addr_lines(upper), .ext_addr_bit_eighteen(bit18), .ext_addr_bit_seventeen(bit17),
    .code_read_strobe_n(crd_n), .data_read_strobe_n(drd_n), .write_strobe_n(wr_n),
    .wait_cycles(wait_cycles), .mem_drive(mem_drive), .mem_data(mem_data), .async_wait_n(wait_n));
  // ==========================================================================
  // Shared tasks
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: %s seen %0h expected %0h", $time, msg, seen, exp);
    end
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // Reset for 8 cycles with the strap at the given level
  task automatic do_reset(input logic s);
    @(posedge clk_sys);
    #1 srst = 1'b1;
    strap = s;
    repeat (8) @(posedge clk_sys);
    #1 srst = 0;
  endtask
  // One request, held until done; watches the pins every cycle
  task automatic xfer(input logic wr, input logic code, input logic [17:0] a, input logic [7:0] wd,
    input logic exp_int, output logic [7:0] rd, output int cyc);
    int nale;
    logic s_crd, s_drd, s_wr, s_done, intl, e_drd;
    logic [1:0] cfg;
    cfg = {cfg_hi, cfg_lo};
    {nale, cyc, s_crd, s_drd, s_wr, s_done, intl} = '0;
    @(posedge clk_sys);
    #1 {req_valid, req_write, req_code, req_addr, req_wdata} = {1'b1, wr, code, a, wd};
    while (!s_done && cyc < 40) begin
      @(posedge clk_sys);
      #1 cyc++;
      if (ale === 1'b1) begin
        nale++;
        chk(upper, a[15:8], "upper lines");
        chk(mux_lvl, a[7:0], "low address on port");
        chk(bit18, (cfg == EMB_CFG_EXT18) & a[17], "address bit 17");
        chk(bit17, (cfg == EMB_CFG_EXT18 || cfg == EMB_CFG_EXT17) & a[16], "address bit 16");
      end
      if (crd_n === 1'b0) s_crd = 1'b1;
      if (drd_n === 1'b0) s_drd = 1'b1;
      if (wr_n === 1'b0) begin
        s_wr = 1'b1;
        chk(oe_n, wd, "write data on port");
      end
      if (done === 1'b1) begin
        {s_done, rd, intl} = {1'b1, rdata, internal};
      end
    end
    req_valid = 1'b0;
    chk(s_done, 1, "request completes");
    chk(intl, exp_int, "served on chip");
    chk(nale, exp_int ? 0 : 1, "latch strobe count");
    e_drd = !exp_int && !wr && !code && cfg == EMB_CFG_DRD;
    chk({s_crd, s_drd, s_wr}, {!exp_int && !wr && !e_drd, e_drd, !exp_int && wr}, "strobe choice");
  endtask
  // ==========================================================================
  // Scenarios
  task automatic t_reset_vals;
    chk({oe_n, ale, crd_n, drd_n, wr_n, done}, {8'hFF, 1'b0, 3'b111, 1'b0}, "reset levels");
    $display("test reset levels done");
  endtask
  // Every bus configuration: write, read back, code read
  task automatic t_cfgs;
    logic [7:0] rd, wd;
    int cyc;
    for (int c = 0; c < 4; c++) begin
      {cfg_hi, cfg_lo} = c[1:0];
      wd = 8'h96 ^ 8'(c);
      xfer(1'b1, 1'b0, 18'h35AC3, wd, 1'b0, rd, cyc);
      xfer(1'b0, 1'b0, 18'h35AC3, 8'h00, 1'b0, rd, cyc);
      chk(rd, wd, "data read back");
      xfer(1'b0, 1'b1, 18'h35A33, 8'h00, 1'b0, rd, cyc);
      chk(rd, 8'h33 ^ 8'h5A, "code read");
    end
    $display("test bus configurations done");
  endtask
  // Wait states stretch the cycle by exactly their count
  task automatic t_wait;
    logic [7:0] rd;
    int c0, c3;
    {cfg_hi, cfg_lo} = EMB_CFG_STD;
    xfer(1'b0, 1'b0, 18'h01234, 8'h00, 1'b0, rd, c0);
    wait_cycles = 4'h3;
    xfer(1'b0, 1'b0, 18'h01234, 8'h00, 1'b0, rd, c3);
    chk(c3 - c0, 3, "wait stretch");
    chk(rd, 8'h34 ^ 8'h12, "read after wait");
    wait_cycles = 4'h0;
    $display("test wait states done");
  endtask
  // Strap caught at reset decides on-chip or external code
  task automatic t_strap;
    logic [7:0] rd;
    int cyc;
    do_reset(1'b1);
    xfer(1'b0, 1'b1, 18'h00123, 8'h00, 1'b1, rd, cyc);
    xfer(1'b0, 1'b1, 18'h08123, 8'h00, 1'b0, rd, cyc);
    strap = 1'b0;
    xfer(1'b0, 1'b1, 18'h00123, 8'h00, 1'b1, rd, cyc);
    do_reset(1'b0);
    xfer(1'b0, 1'b1, 18'h00123, 8'h00, 1'b0, rd, cyc);
    $display("test code select strap done");
  endtask
  // ==========================================================================
  // Main sequence and watchdog
  initial begin
    do_reset(1'b0);
    t_reset_vals();
    t_cfgs();
    t_wait();
    t_strap();
    conclude();
  end
  initial begin
    #100000;
    num_errors++;
    $display("unexpected at %0t: watchdog expired", $time);
    conclude();
  end
endmodule
`default_nettype wire
